// *** src/cfg_mem.sv ***
`timescale 1ns/1ps
module cfg_mem #(
    parameter int AW = 6,
    parameter int DW = 16
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_we,
    input wire logic [AW-1:0] i_waddr,
    input wire logic [DW-1:0] i_wdata,
    input wire logic [AW-1:0] i_raddr,
    output logic [DW-1:0] o_rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // Blank contents stand for the factory state; reset never touches them
    initial begin
        for (int i = 0; i < (1 << AW); i++) begin
            mem[i] = '0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem[i_raddr];
        end
    end
endmodule

// *** src/cfg_pkg.sv ***
// Behaviour
// - With only factory contents and no user configuration every I/O pin stays high impedance and no sequencing or fault response runs.
// - Each configuration command from the management bus puts its value into the working RAM word of that command.
// - The host sends store-all after its parameters; the device then copies working RAM into data flash, with the header word first and the checksum last.
// - Values written into working RAM by bus commands act at once while the system keeps running.
// - Changes to pin functions are not guaranteed to act until the next reset.
// - A downloaded flash image goes straight into data flash, and the old configuration runs on until the next reset applies it.
// - A full image download is accepted during normal operation and needs no immediate reset.
// - A boundary-scan test access port of the 1149.1-1990 kind is provided.
// - Configuration cannot be programmed through the test port, only over the management bus.
// - After reset an initialisation of typically 40 ms runs with all I/O pins high impedance, then the stored configuration runs.
// - At power up a checksum over the stored configuration is checked, and a mismatch discards it, raises alert and sets a flag.
package cfg_pkg;
    localparam int CLK_HZ = 40_000_000;
    localparam int INIT_TIME_MS = 40;
    localparam int INIT_CYCLES_DFLT = INIT_TIME_MS * (CLK_HZ / 1000);
    localparam int CFG_AW_DFLT = 6;
    localparam int CFG_DW_DFLT = 16;
    localparam int HDR_ADDR = 0;
    localparam int PINFN_LO = 1;
    localparam int PINFN_HI = 8;
    localparam logic [15:0] CFG_MAGIC = 16'h5a3c;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    localparam logic [1:0] IR_BYPASS = 2'h3;

    typedef enum logic [2:0] {
        ST_LOAD = 3'h0,
        ST_CHECK = 3'h1,
        ST_CLEAR = 3'h2,
        ST_WAIT = 3'h3,
        ST_IDLE = 3'h4,
        ST_STORE = 3'h5
    } eng_t;

    typedef enum logic [3:0] {
        TAP_RESET = 4'h0,
        TAP_IDLE = 4'h1,
        TAP_SEL_DR = 4'h2,
        TAP_CAP_DR = 4'h3,
        TAP_SH_DR = 4'h4,
        TAP_EX1_DR = 4'h5,
        TAP_PAU_DR = 4'h6,
        TAP_EX2_DR = 4'h7,
        TAP_UPD_DR = 4'h8,
        TAP_SEL_IR = 4'h9,
        TAP_CAP_IR = 4'ha,
        TAP_SH_IR = 4'hb,
        TAP_EX1_IR = 4'hc,
        TAP_PAU_IR = 4'hd,
        TAP_EX2_IR = 4'he,
        TAP_UPD_IR = 4'hf
    } tap_t;
endpackage

// *** src/config_store_and_load.sv ***
`timescale 1ns/1ps
module config_store_and_load
    import cfg_pkg::*;
#(
    parameter int AW = CFG_AW_DFLT,
    parameter int DW = CFG_DW_DFLT,
    parameter int INIT_CYCLES = INIT_CYCLES_DFLT
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_param_wr,
    input wire logic [AW-1:0] i_param_addr,
    input wire logic [DW-1:0] i_param_data,
    input wire logic i_store_all,
    input wire logic i_img_wr,
    input wire logic [AW-1:0] i_img_addr,
    input wire logic [DW-1:0] i_img_data,
    input wire logic [AW-1:0] i_cfg_rd_addr,
    output logic [DW-1:0] o_cfg_rd_data,
    output logic o_busy,
    output logic o_store_done,
    output logic o_run,
    output logic o_pins_hiz,
    output logic o_alert,
    output logic o_cfg_bad,
    output logic o_reset_needed,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    output logic o_tdo,
    output logic o_tdo_oe
);
    localparam logic [AW-1:0] LAST = {AW{1'b1}};
    localparam logic [AW-1:0] HDR = AW'(HDR_ADDR);
    localparam logic [AW-1:0] PIN_LO = AW'(PINFN_LO);
    localparam logic [AW-1:0] PIN_HI = AW'(PINFN_HI);
    localparam logic [DW-1:0] MAGIC = DW'(CFG_MAGIC);
    localparam int TW = $clog2(INIT_CYCLES + 1);
    localparam logic [TW-1:0] INIT_LAST = TW'(INIT_CYCLES - 1);
    localparam int STORE_MAX = (1 << AW) + 3;

    if (DW < 16 || AW < 4 || PINFN_HI >= (1 << AW) || INIT_CYCLES < 1)
    begin : g_bad_params
        $error("config_store_and_load: unsupported parameter values");
    end

    eng_t state;
    logic [AW-1:0] idx;
    logic issue_done;
    logic rd_vld;
    logic [AW-1:0] rd_idx;
    logic [DW-1:0] sum;
    logic [DW-1:0] chk;
    logic magic_ok;
    logic configured;
    logic [TW-1:0] timer;
    logic timer_done;
    logic ram_we;
    logic [AW-1:0] ram_waddr;
    logic [DW-1:0] ram_wdata;
    logic [AW-1:0] ram_raddr;
    logic [DW-1:0] ram_rdata;
    logic flash_we;
    logic [AW-1:0] flash_waddr;
    logic [DW-1:0] flash_wdata;
    logic [DW-1:0] flash_rdata;
    logic param_ok;
    logic img_ok;

    assign param_ok = i_param_wr && state == ST_IDLE;
    assign img_ok = i_img_wr && state == ST_IDLE;
    assign o_busy = state != ST_IDLE;
    assign ram_raddr = (state == ST_STORE) ? idx : i_cfg_rd_addr;
    assign o_cfg_rd_data = ram_rdata;

    cfg_mem #(.AW(AW), .DW(DW)) u_ram (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_we(ram_we),
        .i_waddr(ram_waddr),
        .i_wdata(ram_wdata),
        .i_raddr(ram_raddr),
        .o_rdata(ram_rdata)
    );

    cfg_mem #(.AW(AW), .DW(DW)) u_flash (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_we(flash_we),
        .i_waddr(flash_waddr),
        .i_wdata(flash_wdata),
        .i_raddr(idx),
        .o_rdata(flash_rdata)
    );

    // Working RAM port: loader, clear, then bus commands
    always_comb begin
        ram_we = 1'b0;
        ram_waddr = i_param_addr;
        ram_wdata = i_param_data;
        if (state == ST_LOAD && rd_vld) begin
            ram_we = 1'b1;
            ram_waddr = rd_idx;
            ram_wdata = flash_rdata;
        end else if (state == ST_CLEAR) begin
            ram_we = 1'b1;
            ram_waddr = idx;
            ram_wdata = '0;
        end else if (param_ok) begin
            ram_we = 1'b1;
        end
    end

    // Image writes reach flash only, never RAM
    always_comb begin
        flash_we = 1'b0;
        flash_waddr = i_img_addr;
        flash_wdata = i_img_data;
        if (state == ST_STORE && rd_vld) begin
            flash_we = 1'b1;
            flash_waddr = rd_idx;
            if (rd_idx == HDR) begin
                flash_wdata = MAGIC;
            end else if (rd_idx == LAST) begin
                flash_wdata = sum;
            end else begin
                flash_wdata = ram_rdata;
            end
        end else if (img_ok) begin
            flash_we = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timer <= '0;
            timer_done <= 1'b0;
        end else if (!timer_done) begin
            timer <= timer + 1'b1;
            timer_done <= timer == INIT_LAST;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_LOAD;
            idx <= '0;
            issue_done <= 1'b0;
            rd_vld <= 1'b0;
            rd_idx <= '0;
            sum <= '0;
            chk <= '0;
            magic_ok <= 1'b0;
        end else begin
            case (state)
                ST_LOAD, ST_STORE: begin
                    rd_vld <= !issue_done;
                    rd_idx <= idx;
                    if (!issue_done) begin
                        if (idx == LAST) begin
                            issue_done <= 1'b1;
                        end else begin
                            idx <= idx + 1'b1;
                        end
                    end
                    if (rd_vld && state == ST_LOAD) begin
                        if (rd_idx == HDR) begin
                            magic_ok <= flash_rdata == MAGIC;
                        end
                        if (rd_idx == LAST) begin
                            chk <= flash_rdata;
                            state <= ST_CHECK;
                        end else begin
                            sum <= sum + flash_rdata;
                        end
                    end
                    if (rd_vld && state == ST_STORE) begin
                        if (rd_idx == LAST) begin
                            state <= ST_IDLE;
                        end else begin
                            sum <= sum + flash_wdata;
                        end
                    end
                end
                ST_CHECK: begin
                    idx <= '0;
                    rd_vld <= 1'b0;
                    state <= (sum != chk) ? ST_CLEAR : ST_WAIT;
                end
                ST_CLEAR: begin
                    if (idx == LAST) begin
                        state <= ST_WAIT;
                    end else begin
                        idx <= idx + 1'b1;
                    end
                end
                ST_WAIT: begin
                    if (timer_done) begin
                        state <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (i_store_all) begin
                        state <= ST_STORE;
                        idx <= '0;
                        issue_done <= 1'b0;
                        rd_vld <= 1'b0;
                        sum <= '0;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            configured <= 1'b0;
            o_cfg_bad <= 1'b0;
            o_alert <= 1'b0;
            o_reset_needed <= 1'b0;
            o_run <= 1'b0;
            o_pins_hiz <= 1'b1;
            o_store_done <= 1'b0;
        end else begin
            if (state == ST_CHECK) begin
                configured <= magic_ok && sum == chk;
                o_cfg_bad <= sum != chk;
                o_alert <= sum != chk;
            end
            // Pin roles are latched by the outside logic only at start-up
            if (param_ok && i_param_addr >= PIN_LO &&
                i_param_addr <= PIN_HI) begin
                o_reset_needed <= 1'b1;
            end
            // Keeps running through store-all and image download
            o_run <= configured && (state == ST_IDLE || state == ST_STORE);
            o_pins_hiz <= !(configured &&
                (state == ST_IDLE || state == ST_STORE));
            o_store_done <= state == ST_STORE && rd_vld && rd_idx == LAST;
        end
    end

    // Test port: pins sampled through three stages, no path to config
    logic [2:0] tck_s;
    logic [2:0] tms_s;
    logic [2:0] tdi_s;
    logic tck_lvl;
    logic tck_rise;
    logic tck_fall;
    tap_t tap;
    tap_t next_tap;
    logic [1:0] ir;
    logic [1:0] ir_sh;
    logic byp;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tck_s <= '0;
            tms_s <= 3'h7;
            tdi_s <= '0;
            tck_lvl <= 1'b0;
        end else begin
            tck_s <= {tck_s[1:0], i_tck};
            tms_s <= {tms_s[1:0], i_tms};
            tdi_s <= {tdi_s[1:0], i_tdi};
            if (tck_s[1] == tck_s[2]) begin
                tck_lvl <= tck_s[2];
            end
        end
    end

    assign tck_rise = tck_s[1] == tck_s[2] && tck_s[2] && !tck_lvl;
    assign tck_fall = tck_s[1] == tck_s[2] && !tck_s[2] && tck_lvl;

    always_comb begin
        case (tap)
            TAP_RESET: next_tap = tms_s[2] ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: next_tap = tms_s[2] ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: next_tap = tms_s[2] ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_tap = tms_s[2] ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: next_tap = tms_s[2] ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: next_tap = tms_s[2] ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: next_tap = tms_s[2] ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: next_tap = tms_s[2] ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: next_tap = tms_s[2] ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: next_tap = tms_s[2] ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: next_tap = tms_s[2] ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: next_tap = tms_s[2] ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: next_tap = tms_s[2] ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: next_tap = tms_s[2] ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: next_tap = tms_s[2] ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: next_tap = tms_s[2] ? TAP_SEL_DR : TAP_IDLE;
            default: next_tap = TAP_RESET;
        endcase
    end

    // Every instruction selects the one-bit bypass path
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tap <= TAP_RESET;
            ir <= IR_BYPASS;
            ir_sh <= IR_CAPTURE;
            byp <= 1'b0;
            o_tdo <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else begin
            if (tck_rise) begin
                tap <= next_tap;
                case (tap)
                    TAP_RESET: ir <= IR_BYPASS;
                    TAP_CAP_IR: ir_sh <= IR_CAPTURE;
                    TAP_SH_IR: ir_sh <= {tdi_s[2], ir_sh[1]};
                    TAP_UPD_IR: ir <= ir_sh;
                    TAP_CAP_DR: byp <= 1'b0;
                    TAP_SH_DR: byp <= tdi_s[2];
                    default: byp <= byp;
                endcase
            end
            if (tck_fall) begin
                o_tdo <= (tap == TAP_SH_IR) ? ir_sh[0] : byp;
                o_tdo_oe <= tap == TAP_SH_IR || tap == TAP_SH_DR;
            end
        end
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_bad_check;
        state == ST_CHECK && sum != chk;
    endsequence

    sequence s_store_start;
        state == ST_IDLE && i_store_all ##1 state == ST_STORE;
    endsequence

    AST_UNCONFIG_HIZ:
        assert property (!configured |=> !o_run && o_pins_hiz)
        else $error("run without user configuration");
    AST_PARAM_TO_RAM:
        assert property (param_ok |-> ram_we && ram_waddr == i_param_addr
            && ram_wdata == i_param_data)
        else $error("command value not written to its RAM word");
    AST_STORE_ENDS:
        assert property (s_store_start |-> ##[1:STORE_MAX] o_store_done)
        else $error("store-all did not finish in time");
    AST_STORE_SUM_LAST:
        assert property (o_store_done |-> $past(flash_we)
            && $past(flash_waddr) == LAST)
        else $error("store-all did not end with checksum word");
    AST_PARAM_READBACK:
        assert property (param_ok && i_cfg_rd_addr == i_param_addr ##1
            state == ST_IDLE && !ram_we && $stable(i_cfg_rd_addr)
            |=> o_cfg_rd_data == $past(ram_wdata, 2))
        else $error("written value not visible at once");
    AST_PINFN_FLAG:
        assert property (param_ok && i_param_addr >= PIN_LO
            && i_param_addr <= PIN_HI |=> o_reset_needed)
        else $error("pin function change not flagged");
    AST_IMG_FLASH_ONLY:
        assert property (img_ok |-> flash_we && flash_waddr == i_img_addr
            && !ram_we)
        else $error("image write reached RAM or missed flash");
    AST_IMG_KEEPS_RUN:
        assert property (img_ok && o_run |=> o_run)
        else $error("image download stopped operation");
    AST_TDO_ONLY_SHIFT:
        assert property ($rose(o_tdo_oe) |-> tap == TAP_SH_IR
            || tap == TAP_SH_DR)
        else $error("test data driven outside shift");
    AST_INIT_HIZ:
        assert property (!timer_done |-> o_pins_hiz && !o_run)
        else $error("pins left high impedance too early");
    AST_BAD_ALERT:
        assert property (s_bad_check |=> o_alert && o_cfg_bad
            ##1 state == ST_CLEAR)
        else $error("checksum mismatch not reported");
endmodule

// *** tb/cfg_host.sv ***
`timescale 1ns/1ps
module cfg_host
    import cfg_pkg::*;
#(
    parameter int AW = CFG_AW_DFLT,
    parameter int DW = CFG_DW_DFLT
) (
    input wire logic i_mclk,
    input wire logic i_busy,
    input wire logic i_store_done,
    output logic o_param_wr,
    output logic [AW-1:0] o_param_addr,
    output logic [DW-1:0] o_param_data,
    output logic o_store_all,
    output logic o_img_wr,
    output logic [AW-1:0] o_img_addr,
    output logic [DW-1:0] o_img_data
);
    // Only this host drives the bus, and only one target sits on it
    initial begin
        o_param_wr = 1'b0;
        o_param_addr = '0;
        o_param_data = '0;
        o_store_all = 1'b0;
        o_img_wr = 1'b0;
        o_img_addr = '0;
        o_img_data = '0;
    end

    task automatic put_word(input logic img, input logic [AW-1:0] a,
                            input logic [DW-1:0] d);
        @(negedge i_mclk);
        while (i_busy) @(negedge i_mclk);
        o_img_wr = img;
        o_param_wr = !img;
        o_img_addr = a;
        o_img_data = d;
        o_param_addr = a;
        o_param_data = d;
        @(negedge i_mclk);
        o_img_wr = 1'b0;
        o_param_wr = 1'b0;
        // Released lines flip so a stale value can never look valid
        o_img_addr = ~a;
        o_img_data = ~d;
        o_param_addr = ~a;
        o_param_data = ~d;
    endtask

    // Issued only after all parameters were sent
    task automatic store_all(output int n, output int busy_low);
        @(negedge i_mclk);
        while (i_busy) @(negedge i_mclk);
        o_store_all = 1'b1;
        @(negedge i_mclk);
        o_store_all = 1'b0;
        n = 0;
        busy_low = 0;
        while (n < 80 && !i_store_done) begin
            @(posedge i_mclk);
            #1;
            n++;
            if (!i_store_done && !i_busy) busy_low++;
        end
    endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import cfg_pkg::*;
;
    localparam int AW = CFG_AW_DFLT;
    localparam int DW = CFG_DW_DFLT;
    localparam int NW = 1 << AW;
    localparam int INIT = 100;
    localparam int LIMIT = 20000;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic tck = 1'b0;
    logic tms = 1'b1;
    logic tdi = 1'b0;
    logic [AW-1:0] rd_addr = '0;
    logic param_wr, store_all, img_wr;
    logic [AW-1:0] param_addr, img_addr;
    logic [DW-1:0] param_data, img_data, rd_data;
    logic busy, store_done, run, pins_hiz, alert, cfg_bad, reset_needed;
    logic tdo, tdo_oe;
    logic [31:0] seed = 32'h61167df8;
    logic [DW-1:0] ram_exp [NW];
    logic [DW-1:0] img_exp [NW];
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;

    config_store_and_load #(.AW(AW), .DW(DW), .INIT_CYCLES(INIT))
        config_store_and_load_inst (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_param_wr(param_wr), .i_param_addr(param_addr),
        .i_param_data(param_data), .i_store_all(store_all),
        .i_img_wr(img_wr), .i_img_addr(img_addr), .i_img_data(img_data),
        .i_cfg_rd_addr(rd_addr), .o_cfg_rd_data(rd_data), .o_busy(busy),
        .o_store_done(store_done), .o_run(run), .o_pins_hiz(pins_hiz),
        .o_alert(alert), .o_cfg_bad(cfg_bad),
        .o_reset_needed(reset_needed), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe));

    cfg_host #(.AW(AW), .DW(DW)) cfg_host_inst (
        .i_mclk(i_mclk), .i_busy(busy), .i_store_done(store_done),
        .o_param_wr(param_wr), .o_param_addr(param_addr),
        .o_param_data(param_data), .o_store_all(store_all),
        .o_img_wr(img_wr), .o_img_addr(img_addr), .o_img_data(img_data));

    initial begin
        forever #12.5 i_mclk = ~i_mclk;
    end

    function automatic logic [31:0] nxt();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Checksum over every word but the last, header word included, as the start-up check expects it
    function automatic logic [DW-1:0] csum(input logic [DW-1:0] w [NW]);
        logic [DW-1:0] s;
        s = '0;
        for (int k = 0; k < NW - 1; k++) s = s + w[k];
        return s;
    endfunction

    task automatic chk_word(input logic [DW-1:0] got,
                            input logic [DW-1:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_errors++;
            complete_run();
        end
    end

    task automatic do_reset(output int n);
        @(negedge i_mclk);
        i_rst_n = 1'b0;
        repeat (10) @(negedge i_mclk);
        chk_bit(pins_hiz, 1'b1);
        chk_bit(run, 1'b0);
        i_rst_n = 1'b1;
        n = 0;
        while (busy && n < 2000) begin
            @(negedge i_mclk);
            n++;
            if (busy) chk_bit(pins_hiz, 1'b1);
        end
        // Run and pin state are registered, one cycle behind busy
        @(negedge i_mclk);
    endtask

    task automatic chk_all();
        for (int k = 0; k < NW; k++) begin
            @(negedge i_mclk);
            rd_addr = AW'(k);
            @(posedge i_mclk);
            #1;
            chk_word(rd_data, ram_exp[k]);
        end
    endtask

    task automatic tstep(input logic m);
        logic [31:0] r;
        r = nxt();
        @(negedge i_mclk);
        tms = m;
        tdi = r[0];
        repeat (2) @(negedge i_mclk);
        tck = 1'b1;
        repeat (6) @(negedge i_mclk);
        tck = 1'b0;
        repeat (6) @(negedge i_mclk);
    endtask

    initial begin
        int n, bl;
        logic [31:0] r;
        logic [9:0] path;
        path = 10'b0011011111;
        for (int k = 0; k < NW; k++) ram_exp[k] = '0;
        do_reset(n);
        chk_bit(n >= INIT, 1'b1);
        chk_bit(run, 1'b0);
        chk_bit(pins_hiz, 1'b1);
        chk_bit(alert, 1'b0);
        // Descending so the pin-function boundary at word 8 is seen
        for (int k = NW - 2; k > 0; k--) begin
            r = nxt();
            ram_exp[k] = r[DW-1:0];
            cfg_host_inst.put_word(1'b0, AW'(k), ram_exp[k]);
            if (k == 9) chk_bit(reset_needed, 1'b0);
            if (k == 8) chk_bit(reset_needed, 1'b1);
        end
        chk_all();
        cfg_host_inst.store_all(n, bl);
        chk_bit(n >= NW && n <= NW + 3, 1'b1);
        chk_bit(bl == 0, 1'b1);
        ram_exp[0] = CFG_MAGIC;
        ram_exp[NW-1] = csum(ram_exp);
        do_reset(n);
        chk_bit(run, 1'b1);
        chk_bit(pins_hiz, 1'b0);
        chk_bit(reset_needed, 1'b0);
        chk_all();
        r = nxt();
        ram_exp[20] = r[DW-1:0];
        @(negedge i_mclk);
        rd_addr = AW'(20);
        cfg_host_inst.put_word(1'b0, AW'(20), ram_exp[20]);
        @(posedge i_mclk);
        #1;
        chk_word(rd_data, ram_exp[20]);
        chk_bit(run, 1'b1);
        for (int k = 1; k < NW - 1; k++) begin
            r = nxt();
            img_exp[k] = r[DW-1:0];
        end
        img_exp[0] = CFG_MAGIC;
        img_exp[NW-1] = csum(img_exp);
        for (int k = 0; k < NW; k++) begin
            cfg_host_inst.put_word(1'b1, AW'(k), img_exp[k]);
        end
        chk_bit(run, 1'b1);
        chk_bit(busy, 1'b0);
        chk_all();
        ram_exp = img_exp;
        do_reset(n);
        chk_bit(run, 1'b1);
        chk_all();
        cfg_host_inst.put_word(1'b1, AW'(NW - 1), ~img_exp[NW-1]);
        do_reset(n);
        chk_bit(alert, 1'b1);
        chk_bit(cfg_bad, 1'b1);
        chk_bit(run, 1'b0);
        chk_bit(pins_hiz, 1'b1);
        for (int k = 0; k < NW; k++) ram_exp[k] = '0;
        chk_all();
        for (int k = 0; k < 10; k++) tstep(path[k]);
        chk_bit(tdo, 1'b1);
        chk_bit(tdo_oe, 1'b1);
        tstep(1'b0);
        chk_bit(tdo, 1'b0);
        chk_bit(tdo_oe, 1'b1);
        tstep(1'b1);
        chk_bit(tdo_oe, 1'b0);
        tstep(1'b1);
        tstep(1'b0);
        chk_all();
        chk_bit(alert, 1'b1);
        complete_run();
    end
endmodule
